// file: hw/rfm_map.svh
// Register offsets, field positions, reset values and timing counts of the rail fault monitor
// What this block does
// - Each fault type has its own enable
// - Per fault: latch off or retry forever
// - Power good needs soft-start done, voltage in window
// - Per-rail mask links fault types to power good
// - Overcurrent, overvoltage, undervoltage pull power good low
// - Voltage faults compare regulation sample digitally
// - Overvoltage: disable, record, alert, pulse low side
// - Undervoltage: disable, record, alert, no pulsing
// - Latched voltage fault holds until enable toggles
// - Open sense path suspends the controller
// - Guard phase peak, phase sustained, total sustained
// - Summed current feeds fast and slow filtered paths
// - Total-current paths never touch modulation per cycle
// - Phase peak crossing drives that phase's modulation to its I_PHASE_NEG level
// - Peak limit: forever, or fault after count
// - Stage overrange flag shuts rail down at once
// - Thermal warning meaningful only once enabled
// - Temperature warning and fault thresholds independent
// - Warning asserts output, no fault, no stop
// - Power good and warning may show thermal states
// - Shutdown rail holds modulation outputs high impedance
`ifndef RFM_MAP_SVH
`define RFM_MAP_SVH

// Word offsets (byte address = 4 * index)
`define RFM_IDX_FAULT_EN      4'h0
`define RFM_IDX_RETRY_EN      4'h1
`define RFM_IDX_PG_MASK0      4'h2
`define RFM_IDX_PG_MASK1      4'h3
`define RFM_IDX_OV_TH         4'h4
`define RFM_IDX_UV_TH         4'h5
`define RFM_IDX_PEAK_TH       4'h6
`define RFM_IDX_PHASE_TH      4'h7
`define RFM_IDX_FAST_CFG      4'h8
`define RFM_IDX_SLOW_CFG      4'h9
`define RFM_IDX_TEMP_TH       4'hA
`define RFM_IDX_MISC_CFG      4'hB
`define RFM_IDX_STATUS0       4'hC
`define RFM_IDX_STATUS1       4'hD
`define RFM_IDX_LIVE          4'hE

// Fault type bit positions
`define RFM_F_OV      0
`define RFM_F_UV      1
`define RFM_F_PEAK    2
`define RFM_F_PHASE   3
`define RFM_F_FAST    4
`define RFM_F_SLOW    5
`define RFM_F_STAGE   6
`define RFM_F_OTEMP   7
`define RFM_F_OPEN    8
`define RFM_F_THERMAL_WARNING_OUT   9

// MISC_CFG fields
`define RFM_MISC_STAGE_DET    0
`define RFM_MISC_PG_TEMP      1
`define RFM_MISC_TW_FAULT     2
`define RFM_MISC_PEAK_FOREVER 3

// Reset values
`define RFM_RST_FAULT_EN  32'h0000_01FF
`define RFM_RST_PG_MASK   32'h0000_01FF
`define RFM_RST_ZERO      32'h0000_0000
`define RFM_RST_OV_TH     32'h0000_0E00
`define RFM_RST_UV_TH     32'h0000_0200
`define RFM_RST_PEAK_TH   32'h0000_0F00
`define RFM_RST_PHASE_TH  32'h0000_0C00
`define RFM_RST_FILT_CFG  32'h0004_0E00
`define RFM_RST_TEMP_TH   32'h0078_0064
`define RFM_RST_MISC      32'h0008_0001

// Timing
`define RFM_SS_TIME_US    200
`define RFM_CLK_MHZ       100

`endif

// file: hw/rfm_pkg.sv
// Types of the rail fault monitor
package rfm_pkg;
    typedef enum logic [3:0] {
        RFM_OFF   = 4'b0001,
        RFM_SOFT  = 4'b0010,
        RFM_RUN   = 4'b0100,
        RFM_FAULT = 4'b1000
    } rfm_rail_e;
endpackage

// file: hw/rfm_monitor.sv
// Rail fault monitor: detection, protective response, power good and thermal warning
`timescale 1ns/1ps
`include "rfm_map.svh"
module rfm_monitor
    import rfm_pkg::*;
#(
    parameter int PHASES  = 7,
    parameter int DW      = 12,
    parameter int SS_CYC  = `RFM_SS_TIME_US * `RFM_CLK_MHZ
) (
    input  wire logic                  I_CLK,
    input  wire logic                  I_RSTN,
    // Avalon-MM slave
    input  wire logic [5:0]            I_AVS_ADDRESS,
    input  wire logic                  I_AVS_READ,
    input  wire logic                  I_AVS_WRITE,
    input  wire logic [31:0]           I_AVS_WRITEDATA,
    input  wire logic [3:0]            I_AVS_BYTEENABLE,
    output logic      [31:0]           O_AVS_READDATA,
    output logic                       O_AVS_WAITREQUEST,
    output logic      [1:0]            O_AVS_RESPONSE,
    // Sensed quantities
    input  wire logic [1:0]            I_RAIL_ENABLE,
    input  wire logic [1:0][DW-1:0]    I_VOUT_SAMPLE,
    input  wire logic [1:0]            I_SENSE_OPEN,
    input  wire logic [PHASES-1:0]     I_PHASE_RAIL,
    input  wire logic [PHASES-1:0][DW-1:0] I_PHASE_CURRENT,
    input  wire logic [PHASES-1:0]     I_PHASE_NEG,
    input  wire logic [PHASES-1:0]     I_STAGE_OVERRANGE,
    input  wire logic [DW-1:0]         I_TEMP,
    input  wire logic [PHASES-1:0]     I_PWM_IN,
    input  wire logic [PHASES-1:0]     I_CYCLE_TICK,
    // Outputs
    output logic      [PHASES-1:0]     O_PWM,
    output logic      [PHASES-1:0]     O_PWM_OE,
    output logic      [PHASES-1:0]     O_LOW_SIDE_SWITCH,
    output logic      [1:0]            O_RAIL_ACTIVE,
    output logic      [1:0]            O_RAIL_POWER_GOOD_OUT_O,
    output logic      [1:0]            O_RAIL_POWER_GOOD_OUT_OE,
    output logic                       O_THERMAL_WARNING_OUT_O,
    output logic                       O_THERMAL_WARNING_OUT_OE,
    output logic                       O_BUS_ALERT_LINE_O,
    output logic                       O_BUS_ALERT_LINE_OE
);
    localparam int NF = 10;
    initial begin
        if (PHASES < 1 || PHASES > 16 || DW < 4 || DW > 16 || SS_CYC < 1)
            $error("rfm_monitor: unsupported parameter values");
    end

    // Configuration registers
    logic [31:0] fault_en_reg, retry_reg, misc_reg, ov_reg, uv_reg, peak_reg, phase_reg;
    logic [31:0] fast_reg, slow_reg, temp_reg;
    logic [1:0][31:0] pg_mask_reg;
    logic [1:0][NF-1:0] status_reg;
    logic [1:0][NF-1:0] live;
    logic [1:0]         phase_cnt_fault;

    // Byte-enable merge of a write into a word
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[8*b +: 8] = wd[8*b +: 8];
        end
        return r;
    endfunction

    // Bus decode: one wait state per access, then the answer
    logic       ack_reg;
    wire        req      = (I_AVS_READ | I_AVS_WRITE) & ~ack_reg;
    wire [3:0]  widx     = I_AVS_ADDRESS[5:2];
    wire        wr_ok    = I_AVS_WRITE & ack_reg;
    wire        mapped   = (widx <= `RFM_IDX_LIVE) && (I_AVS_ADDRESS[1:0] == 2'b00);
    assign O_AVS_WAITREQUEST = req;
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) ack_reg <= 1'b0;
        else         ack_reg <= req;
    end

    // Read mux, registered for the answer edge
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (widx)
            `RFM_IDX_FAULT_EN: rd_mux = fault_en_reg;
            `RFM_IDX_RETRY_EN: rd_mux = retry_reg;
            `RFM_IDX_PG_MASK0: rd_mux = pg_mask_reg[0];
            `RFM_IDX_PG_MASK1: rd_mux = pg_mask_reg[1];
            `RFM_IDX_OV_TH:    rd_mux = ov_reg;
            `RFM_IDX_UV_TH:    rd_mux = uv_reg;
            `RFM_IDX_PEAK_TH:  rd_mux = peak_reg;
            `RFM_IDX_PHASE_TH: rd_mux = phase_reg;
            `RFM_IDX_FAST_CFG: rd_mux = fast_reg;
            `RFM_IDX_SLOW_CFG: rd_mux = slow_reg;
            `RFM_IDX_TEMP_TH:  rd_mux = temp_reg;
            `RFM_IDX_MISC_CFG: rd_mux = misc_reg;
            `RFM_IDX_STATUS0:  rd_mux = {22'h00_0000, status_reg[0]};
            `RFM_IDX_STATUS1:  rd_mux = {22'h00_0000, status_reg[1]};
            `RFM_IDX_LIVE:     rd_mux = {2'b00, O_RAIL_ACTIVE, 8'h00, live[1], live[0]};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            O_AVS_READDATA <= 32'h0000_0000;
            O_AVS_RESPONSE <= 2'b00;
        end else if (req) begin
            O_AVS_READDATA <= mapped ? rd_mux : 32'h0000_0000;
            O_AVS_RESPONSE <= mapped ? 2'b00 : 2'b10;
        end
    end

    // Writable configuration
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            fault_en_reg   <= `RFM_RST_FAULT_EN;
            retry_reg      <= `RFM_RST_ZERO;
            pg_mask_reg[0] <= `RFM_RST_PG_MASK;
            pg_mask_reg[1] <= `RFM_RST_PG_MASK;
            ov_reg         <= `RFM_RST_OV_TH;
            uv_reg         <= `RFM_RST_UV_TH;
            peak_reg       <= `RFM_RST_PEAK_TH;
            phase_reg      <= `RFM_RST_PHASE_TH;
            fast_reg       <= `RFM_RST_FILT_CFG;
            slow_reg       <= `RFM_RST_FILT_CFG;
            temp_reg       <= `RFM_RST_TEMP_TH;
            misc_reg       <= `RFM_RST_MISC;
        end else if (wr_ok && mapped) begin
            unique case (widx)
                `RFM_IDX_FAULT_EN: fault_en_reg <= be_merge(fault_en_reg, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                `RFM_IDX_RETRY_EN: retry_reg <= be_merge(retry_reg, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                `RFM_IDX_PG_MASK0: pg_mask_reg[0] <= be_merge(pg_mask_reg[0], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                `RFM_IDX_PG_MASK1: pg_mask_reg[1] <= be_merge(pg_mask_reg[1], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                `RFM_IDX_OV_TH:    ov_reg    <= be_merge(ov_reg, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                `RFM_IDX_UV_TH:    uv_reg    <= be_merge(uv_reg, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                `RFM_IDX_PEAK_TH:  peak_reg  <= be_merge(peak_reg, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                `RFM_IDX_PHASE_TH: phase_reg <= be_merge(phase_reg, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                `RFM_IDX_FAST_CFG: fast_reg  <= be_merge(fast_reg, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                `RFM_IDX_SLOW_CFG: slow_reg  <= be_merge(slow_reg, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                `RFM_IDX_TEMP_TH:  temp_reg  <= be_merge(temp_reg, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                `RFM_IDX_MISC_CFG: misc_reg  <= be_merge(misc_reg, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                default: ;
            endcase
        end
    end

    // Per-phase peak and sustained detection
    logic [PHASES-1:0] peak_hit, sus_hit, peak_fault;
    logic [PHASES-1:0][7:0] peak_cnt_reg;
    logic [PHASES-1:0][DW+3:0] sus_acc_reg;
    wire  [7:0] peak_limit = peak_reg[23:16];
    genvar p;
    generate
        for (p = 0; p < PHASES; p++) begin : g_phase
            assign peak_hit[p] = I_PHASE_CURRENT[p] > peak_reg[DW-1:0];
            // Sustained current as a slow running average over sixteen samples
            always_ff @(posedge I_CLK) begin
                if (!I_RSTN) sus_acc_reg[p] <= '0;
                else sus_acc_reg[p] <= sus_acc_reg[p] - (sus_acc_reg[p] >> 4)
                                       + {4'h0, I_PHASE_CURRENT[p]};
            end
            assign sus_hit[p] = sus_acc_reg[p][DW+3:4] > phase_reg[DW-1:0];
            // Consecutive limited cycles
            always_ff @(posedge I_CLK) begin
                if (!I_RSTN) peak_cnt_reg[p] <= 8'h00;
                else if (I_CYCLE_TICK[p]) begin
                    if (!peak_hit[p]) peak_cnt_reg[p] <= 8'h00;
                    else if (peak_cnt_reg[p] != 8'hFF) peak_cnt_reg[p] <= peak_cnt_reg[p] + 8'h01;
                end
            end
            assign peak_fault[p] = ~misc_reg[`RFM_MISC_PEAK_FOREVER] && peak_hit[p]
                                   && (peak_cnt_reg[p] >= peak_limit);
        end
    endgenerate

    // Summed current with fast and slow filtered paths
    logic [1:0][DW+3:0] summed_phase_current;
    logic [1:0][DW+7:0] fast_f_reg, slow_f_reg;
    logic [1:0][15:0]   fast_t_reg, slow_t_reg;
    logic [1:0]         fast_trip, slow_trip;
    always_comb begin
        summed_phase_current = '0;
        for (int i = 0; i < PHASES; i++) begin
            summed_phase_current[I_PHASE_RAIL[i]] = summed_phase_current[I_PHASE_RAIL[i]] + (DW+4)'(I_PHASE_CURRENT[i]);
        end
    end
    genvar r;
    generate
        for (r = 0; r < 2; r++) begin : g_sum
            // First-order filters, shift from config bits 19:16; timers bits 31:24 are response
            always_ff @(posedge I_CLK) begin
                if (!I_RSTN) begin
                    fast_f_reg[r] <= '0;
                    slow_f_reg[r] <= '0;
                    fast_t_reg[r] <= 16'h0000;
                    slow_t_reg[r] <= 16'h0000;
                end else begin
                    fast_f_reg[r] <= fast_f_reg[r] - (fast_f_reg[r] >> fast_reg[19:16])
                                     + {4'h0, summed_phase_current[r]};
                    slow_f_reg[r] <= slow_f_reg[r] - (slow_f_reg[r] >> slow_reg[19:16])
                                     + {4'h0, summed_phase_current[r]};
                    fast_t_reg[r] <= ((fast_f_reg[r] >> fast_reg[19:16]) > (DW+8)'(fast_reg[15:0]))
                                     ? fast_t_reg[r] + 16'h0001 : 16'h0000;
                    slow_t_reg[r] <= ((slow_f_reg[r] >> slow_reg[19:16]) > (DW+8)'(slow_reg[15:0]))
                                     ? slow_t_reg[r] + 16'h0001 : 16'h0000;
                end
            end
            // Trip only through fault response, never per switching cycle
            assign fast_trip[r] = fast_t_reg[r] > {8'h00, fast_reg[31:24]};
            assign slow_trip[r] = slow_t_reg[r] > {8'h00, slow_reg[31:24]};
        end
    endgenerate

    // Temperature thresholds
    wire temp_warn  = I_TEMP >= temp_reg[DW-1:0];
    wire temp_fault = I_TEMP >= temp_reg[16+DW-1:16];

    // Live conditions per rail
    rfm_rail_e [1:0] st_reg;
    logic [1:0] ss_done;
    generate
        for (r = 0; r < 2; r++) begin : g_live
            wire [PHASES-1:0] on_rail = (r == 0) ? ~I_PHASE_RAIL : I_PHASE_RAIL;
            assign live[r][`RFM_F_OV]    = I_VOUT_SAMPLE[r] > ov_reg[DW-1:0];
            assign live[r][`RFM_F_UV]    = (st_reg[r] == RFM_RUN) &&
                                            (I_VOUT_SAMPLE[r] < uv_reg[DW-1:0]);
            assign live[r][`RFM_F_PEAK]  = |(peak_fault & on_rail);
            assign live[r][`RFM_F_PHASE] = |(sus_hit & on_rail);
            assign live[r][`RFM_F_FAST]  = fast_trip[r];
            assign live[r][`RFM_F_SLOW]  = slow_trip[r];
            assign live[r][`RFM_F_STAGE] = misc_reg[`RFM_MISC_STAGE_DET]
                                           && |(I_STAGE_OVERRANGE & on_rail);
            assign live[r][`RFM_F_OTEMP] = temp_fault;
            assign live[r][`RFM_F_OPEN]  = I_SENSE_OPEN[r];
            assign live[r][`RFM_F_THERMAL_WARNING_OUT] = temp_warn;
        end
    endgenerate

    // Rail state machines and responses
    logic [1:0][NF-1:0] act;
    logic [1:0]         trip, retry_ok, en_prev_reg, latched_reg;
    logic [1:0][31:0]   ss_cnt_reg;
    generate
        for (r = 0; r < 2; r++) begin : g_rail
            // Warning never trips; enabled faults other than open sense do
            assign act[r]   = live[r] & fault_en_reg[NF-1:0] & ~(NF'(1) << `RFM_F_THERMAL_WARNING_OUT);
            assign trip[r]  = |act[r][`RFM_F_OPEN-1:0];
            assign retry_ok[r] = ~|(status_reg[r][`RFM_F_OPEN-1:0] & ~retry_reg[`RFM_F_OPEN-1:0]);
            assign ss_done[r] = st_reg[r] == RFM_RUN;
            always_ff @(posedge I_CLK) begin
                if (!I_RSTN) begin
                    st_reg[r]      <= RFM_OFF;
                    ss_cnt_reg[r]  <= 32'h0000_0000;
                    en_prev_reg[r] <= 1'b0;
                    latched_reg[r] <= 1'b0;
                end else begin
                    en_prev_reg[r] <= I_RAIL_ENABLE[r];
                    unique case (st_reg[r])
                        RFM_OFF: if (I_RAIL_ENABLE[r] && !act[r][`RFM_F_OPEN]) begin
                            st_reg[r]     <= RFM_SOFT;
                            ss_cnt_reg[r] <= 32'h0000_0000;
                        end
                        RFM_SOFT, RFM_RUN: begin
                            if (act[r][`RFM_F_OPEN]) st_reg[r] <= RFM_OFF;
                            else if (!I_RAIL_ENABLE[r]) st_reg[r] <= RFM_OFF;
                            else if (trip[r]) begin
                                st_reg[r]      <= RFM_FAULT;
                                latched_reg[r] <= 1'b1;
                            end else if (st_reg[r] == RFM_SOFT) begin
                                ss_cnt_reg[r] <= ss_cnt_reg[r] + 32'h0000_0001;
                                if (ss_cnt_reg[r] >= 32'(SS_CYC - 1)) st_reg[r] <= RFM_RUN;
                            end
                        end
                        RFM_FAULT: begin
                            if (!I_RAIL_ENABLE[r] && en_prev_reg[r]) begin
                                st_reg[r]      <= RFM_OFF;
                                latched_reg[r] <= 1'b0;
                            end else if (retry_ok[r] && !trip[r] && !act[r][`RFM_F_OPEN]) begin
                                st_reg[r]      <= RFM_SOFT;
                                ss_cnt_reg[r]  <= 32'h0000_0000;
                                latched_reg[r] <= 1'b0;
                            end
                        end
                        default: st_reg[r] <= RFM_OFF;
                    endcase
                end
            end
            // Sticky status; a new event wins over the clear
            always_ff @(posedge I_CLK) begin
                if (!I_RSTN) status_reg[r] <= '0;
                else if (wr_ok && mapped && widx == (r == 0 ? `RFM_IDX_STATUS0 : `RFM_IDX_STATUS1))
                    status_reg[r] <= (status_reg[r] & ~I_AVS_WRITEDATA[NF-1:0]) | act[r];
                else
                    status_reg[r] <= status_reg[r] | act[r];
            end
            // Power good: run state, in window, no linked fault, optional thermal
            wire pg_fault = |(status_reg[r] & pg_mask_reg[r][NF-1:0] & ~(NF'(1) << `RFM_F_THERMAL_WARNING_OUT))
                            | live[r][`RFM_F_OV] | live[r][`RFM_F_UV]
                            | (|(act[r][`RFM_F_FAST:`RFM_F_PEAK]))
                            | (misc_reg[`RFM_MISC_PG_TEMP] & (temp_warn | temp_fault));
            always_ff @(posedge I_CLK) begin
                if (!I_RSTN) O_RAIL_POWER_GOOD_OUT_OE[r] <= 1'b1;
                else O_RAIL_POWER_GOOD_OUT_OE[r] <= ~(ss_done[r] & ~pg_fault);
            end
        end
    endgenerate
    assign O_RAIL_POWER_GOOD_OUT_O = 2'b00;

    // Modulation: shutdown tristates, peak crossing drives the I_PHASE_NEG level, overvoltage pulses low side
    logic [PHASES-1:0] pwm_reg, oe_reg, ls_reg, ls_tog_reg;
    generate
        for (p = 0; p < PHASES; p++) begin : g_pwm
            wire rr  = I_PHASE_RAIL[p];
            wire run = (st_reg[rr] == RFM_SOFT) || (st_reg[rr] == RFM_RUN);
            wire overvoltage_protection = (st_reg[rr] == RFM_FAULT) && live[rr][`RFM_F_OV] && fault_en_reg[`RFM_F_OV];
            wire pk  = peak_hit[p] & (I_PWM_IN[p] ^ I_PHASE_NEG[p]);
            always_ff @(posedge I_CLK) begin
                if (!I_RSTN) begin
                    pwm_reg[p] <= 1'b0;
                    oe_reg[p]  <= 1'b0;
                    ls_reg[p]  <= 1'b0;
                    ls_tog_reg[p] <= 1'b0;
                end else begin
                    pwm_reg[p] <= run ? (I_PWM_IN[p] ^ pk) : 1'b0;
                    oe_reg[p]  <= run;
                    ls_tog_reg[p] <= overvoltage_protection ? ~ls_tog_reg[p] : 1'b0;
                    ls_reg[p]  <= overvoltage_protection & ls_tog_reg[p];
                end
            end
        end
    endgenerate
    assign O_PWM             = pwm_reg;
    assign O_PWM_OE          = oe_reg;
    assign O_LOW_SIDE_SWITCH = ls_reg;
    assign O_RAIL_ACTIVE     = {ss_done[1] | (st_reg[1] == RFM_SOFT),
                                ss_done[0] | (st_reg[0] == RFM_SOFT)};

    // Thermal warning only after enable; alert while any sticky fault stands
    logic tw_reg, alert_reg;
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            tw_reg    <= 1'b0;
            alert_reg <= 1'b0;
        end else begin
            tw_reg    <= (|I_RAIL_ENABLE) && fault_en_reg[`RFM_F_THERMAL_WARNING_OUT] && (temp_warn
                         || (misc_reg[`RFM_MISC_TW_FAULT] && temp_fault));
            alert_reg <= |{status_reg[1][`RFM_F_OPEN:0], status_reg[0][`RFM_F_OPEN:0]};
        end
    end
    assign O_THERMAL_WARNING_OUT_O  = 1'b0;
    assign O_THERMAL_WARNING_OUT_OE = tw_reg;
    assign O_BUS_ALERT_LINE_O       = 1'b0;
    assign O_BUS_ALERT_LINE_OE      = alert_reg;
endmodule

// file: testbench/rfm_monitor_props.sv
// Concurrent checks on the rail fault monitor ports
`timescale 1ns/1ps
module rfm_monitor_props #(
    parameter int PHASES = 7,
    parameter int DW     = 12
) (
    input wire logic              I_CLK,
    input wire logic              I_RSTN,
    input wire logic [1:0]        I_RAIL_ENABLE,
    input wire logic [1:0]        I_SENSE_OPEN,
    input wire logic [PHASES-1:0] I_PHASE_RAIL,
    input wire logic [PHASES-1:0] I_STAGE_OVERRANGE,
    input wire logic [DW-1:0]     I_TEMP,
    input wire logic [PHASES-1:0] O_PWM_OE,
    input wire logic [1:0]        O_RAIL_ACTIVE,
    input wire logic [1:0]        O_RAIL_POWER_GOOD_OUT_OE,
    input wire logic              O_THERMAL_WARNING_OUT_OE,
    input wire logic              O_BUS_ALERT_LINE_OE
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    property p_ss; $rose(O_RAIL_ACTIVE[0]) |-> O_RAIL_POWER_GOOD_OUT_OE[0] [*8]; endproperty
    a_ss: assert property (p_ss) else $error("power good early");
    property p_pg; !O_RAIL_POWER_GOOD_OUT_OE[0] |-> $past(O_RAIL_ACTIVE[0]); endproperty
    a_pg: assert property (p_pg) else $error("power good on idle rail");
    property p_fpg; $fell(O_RAIL_ACTIVE[0]) && I_RAIL_ENABLE[0]
        |-> ##[0:2] O_RAIL_POWER_GOOD_OUT_OE[0]; endproperty
    a_fpg: assert property (p_fpg) else $error("fault left power good");
    property p_al; $fell(O_RAIL_ACTIVE[0]) && I_RAIL_ENABLE[0] && !I_SENSE_OPEN[0]
        |-> ##[0:2] O_BUS_ALERT_LINE_OE; endproperty
    a_al: assert property (p_al) else $error("fault without alert");
    property p_hz; !O_RAIL_ACTIVE[0] [*2] |-> (O_PWM_OE & ~I_PHASE_RAIL) == '0; endproperty
    a_hz: assert property (p_hz) else $error("off rail drives modulation");
    property p_st; O_RAIL_ACTIVE[0] && |(I_STAGE_OVERRANGE & ~I_PHASE_RAIL)
        |-> ##[1:2] !O_RAIL_ACTIVE[0]; endproperty
    a_st: assert property (p_st) else $error("stage flag ignored");
    property p_op; I_SENSE_OPEN[0] && O_RAIL_ACTIVE[0] |-> ##[1:2] !O_RAIL_ACTIVE[0]; endproperty
    a_op: assert property (p_op) else $error("open sense ignored");
    property p_tw; $rose(O_THERMAL_WARNING_OUT_OE) && I_TEMP < 12'h078
        && $past(O_RAIL_ACTIVE[0]) |-> O_RAIL_ACTIVE[0]; endproperty
    a_tw: assert property (p_tw) else $error("warning stopped rail");
endmodule
bind rfm_monitor rfm_monitor_props #(.PHASES(PHASES), .DW(DW)) u_props (.I_CLK, .I_RSTN,
    .I_RAIL_ENABLE, .I_SENSE_OPEN, .I_PHASE_RAIL, .I_STAGE_OVERRANGE, .I_TEMP, .O_PWM_OE,
    .O_RAIL_ACTIVE, .O_RAIL_POWER_GOOD_OUT_OE, .O_THERMAL_WARNING_OUT_OE, .O_BUS_ALERT_LINE_OE);

// file: testbench/rfm_stage_model.sv
// Power stages and pull-ups at the far side of the monitor
`timescale 1ns/1ps
module rfm_stage_model (
    input  wire logic [1:0] i_en_req,
    input  wire logic [6:0] i_stage_fault,
    input  wire logic [6:0] i_phase_rail,
    input  wire logic [1:0] i_pg_oe,
    output logic      [1:0] o_rail_enable,
    output logic      [1:0] o_pg_wire
);
    // Stage fault pin pulls down the enable of its own rail
    assign o_rail_enable[0] = i_en_req[0] & ~|(i_stage_fault & ~i_phase_rail);
    assign o_rail_enable[1] = i_en_req[1] & ~|(i_stage_fault & i_phase_rail);
    assign o_pg_wire = ~i_pg_oe; // Pulled up unless driven low
endmodule

// file: testbench/test_rfm_monitor.sv
// Self-checking bench for the rail fault monitor
`timescale 1ns/1ps
`include "rfm_map.svh"
module test_rfm_monitor;
    logic             clk = 0, rstn = 0, rd = 0, wr = 0, wt, tw, al, ls_seen = 0;
    logic [5:0]       adr = '0;
    logic [31:0]      wd = '0, rdat, q;
    logic [1:0]       en_req = '0, act, pg_oe, pgw, en, resp, rs, so = '0;
    logic [1:0][11:0] vout = {12'h800, 12'h800};
    logic [6:0]       ovr = '0, ls, poe, pwm, sf = '0, ng = '0, prl = 7'h60;
    logic [6:0][11:0] cur = '0;
    logic [11:0]      temp = 12'h020;
    int               num_errors = 0, check_count = 0, cyc = 0;
    always #5 clk = ~clk;
    rfm_monitor #(.SS_CYC(8)) dut (.I_CLK(clk), .I_RSTN(rstn), .I_AVS_ADDRESS(adr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hF),
        .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wt), .O_AVS_RESPONSE(resp),
        .I_RAIL_ENABLE(en), .I_VOUT_SAMPLE(vout), .I_SENSE_OPEN(so), .I_PHASE_RAIL(prl),
        .I_PHASE_CURRENT(cur), .I_PHASE_NEG(ng), .I_STAGE_OVERRANGE(ovr), .I_TEMP(temp),
        .I_PWM_IN(7'h00), .I_CYCLE_TICK(7'h00), .O_PWM(pwm), .O_PWM_OE(poe),
        .O_LOW_SIDE_SWITCH(ls), .O_RAIL_ACTIVE(act), .O_RAIL_POWER_GOOD_OUT_O(),
        .O_RAIL_POWER_GOOD_OUT_OE(pg_oe), .O_THERMAL_WARNING_OUT_O(),
        .O_THERMAL_WARNING_OUT_OE(tw), .O_BUS_ALERT_LINE_O(), .O_BUS_ALERT_LINE_OE(al));
    rfm_stage_model model (.i_en_req(en_req), .i_stage_fault(sf), .i_phase_rail(prl),
        .i_pg_oe(pg_oe), .o_rail_enable(en), .o_pg_wire(pgw));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Cycle ceiling and low-side activity watch on rail 0 phases
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (|ls[4:0]) ls_seen <= 1;
        if (cyc == 5000) begin
            num_errors++;
            print_verdict;
        end
    end
    // One bus access, held until waitrequest is low at a rising edge
    task automatic acc(input logic w, input logic [3:0] i, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= {i, 2'b00};
        wd <= d;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat;
        rs = resp;
        rd <= 0;
        wr <= 0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [3:0] i, input logic [31:0] e);
        acc(0, i, 32'h0000_0000);
        chk(q, e);
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic cyc_en;
        en_req <= 2'b00;
        tk(2);
        en_req <= 2'b01;
    endtask
    // Scenario sequence
    initial begin
        tk(4);
        rstn <= 1;
        @(posedge clk);
        rdc(`RFM_IDX_FAULT_EN, `RFM_RST_FAULT_EN);
        rdc(`RFM_IDX_TEMP_TH, `RFM_RST_TEMP_TH);
        rdc(4'hF, 32'h0000_0000);
        chk(rs, 2'b10);
        acc(1, `RFM_IDX_FAULT_EN, 32'h0000_03FF);
        en_req <= 2'b01;
        tk(20);
        chk(pgw[0], 1'b1);
        acc(1, `RFM_IDX_MISC_CFG, 32'h0000_0003);
        temp <= 12'h070;
        tk(4);
        chk({tw, act[0], pgw[0]}, 3'b110);
        temp <= 12'h020;
        acc(1, `RFM_IDX_STATUS0, 32'h0000_03FF);
        acc(1, `RFM_IDX_FAULT_EN, 32'h0000_03FE);
        vout[0] <= 12'hF00;
        tk(6);
        chk(act[0], 1'b1);
        ls_seen <= 0;
        acc(1, `RFM_IDX_FAULT_EN, 32'h0000_03FF);
        tk(4);
        chk({act[0], pg_oe[0], al, ls_seen}, 4'b0111);
        rdc(`RFM_IDX_STATUS0, 32'h0000_0001);
        vout[0] <= 12'h800;
        tk(20);
        chk(act[0], 1'b0);
        cyc_en;
        tk(20);
        chk(act[0], 1'b1);
        acc(1, `RFM_IDX_STATUS0, 32'h0000_03FF);
        rdc(`RFM_IDX_STATUS0, 32'h0000_0000);
        ls_seen <= 0;
        vout[0] <= 12'h100;
        tk(4);
        chk({act[0], al, ls_seen}, 3'b010);
        vout[0] <= 12'h800;
        cyc_en;
        acc(1, `RFM_IDX_STATUS0, 32'h0000_03FF);
        acc(1, `RFM_IDX_RETRY_EN, 32'h0000_00FF);
        for (int k = 0; k < 2; k++) begin
            tk(12);
            vout[0] <= 12'hF00;
            tk(4);
            chk(act[0], 1'b0);
            vout[0] <= 12'h800;
            tk(6);
            chk(act[0], 1'b1);
        end
        cur[0] <= 12'hF80;
        ng <= 7'h01;
        tk(2);
        chk(pwm[0], 1'b1);
        cur[0] <= 12'h000;
        rdc(`RFM_IDX_STATUS0, 32'h0000_0005);
        so <= 2'b01;
        tk(2);
        chk(act[0], 1'b0);
        so <= 2'b00;
        ovr <= 7'h01;
        tk(3);
        chk(act[0], 1'b0);
        ovr <= 7'h00;
        sf <= 7'h01;
        tk(3);
        chk(act[0], 1'b0);
        print_verdict;
    end
endmodule
